// ===== hdl/apus_pkg.sv
// ----------------------------------------------------------------------------
// Power sequencer constants
// ----------------------------------------------------------------------------
package apus_pkg;

    // Power modes of the converter.
    typedef enum logic [1:0] {
        APUS_NORMAL  = 2'b00,
        APUS_PARTIAL = 2'b01,
        APUS_FULL    = 2'b10
    } apus_mode_t;

    // Cycle state of the select framing.
    typedef enum logic [1:0] {
        APUS_IDLE    = 2'b00,
        APUS_FRAME   = 2'b01
    } apus_frame_t;

    // System clock rate in hertz.
    localparam int unsigned CLK_HZ         = 20_000_000;
    // Recovery time with the internal reference, in nanoseconds.
    localparam int unsigned REC_INT_NS     = 4000;
    // Recovery time with an external reference, in nanoseconds.
    localparam int unsigned REC_EXT_NS     = 1000;
    // Recovery time from full power-down, in microseconds.
    localparam int unsigned REC_FULL_US    = 4000;
    // Derived cycle counts (least times round up).
    localparam int unsigned REC_INT_CYC    = (REC_INT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned REC_EXT_CYC    = (REC_EXT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned REC_FULL_CYC   = REC_FULL_US * (CLK_HZ / 1_000_000);
    // Falling edge counts that bound the power-down window.
    localparam logic [5:0]  EDGE_WIN_LO    = 6'h02;
    localparam logic [5:0]  EDGE_WIN_HI    = 6'h0A;
    // Falling edges after which tracking resumes in a normal frame.
    localparam logic [5:0]  EDGE_TRACK     = 6'h0D;
    // Falling edges that end a dual read.
    localparam logic [5:0]  EDGE_END       = 6'h20;
    // Width of the recovery counter.
    localparam int unsigned REC_W          = 18;

endpackage

// ===== hdl/apus_sequencer.sv
// Behaviour
// - Internal reference partial recovery takes 4 us.
// - External reference partial recovery takes 1 us.
// - Reference buffers re-power only with internal reference.
// - Track resumes on first clock edge after select in a recovery frame.
// - Track-and-hold starts in track at power-up.
// - Select low ten falling edges keeps power.
// - Rise in window aborts, tri-states, partial down.
// - Window rise in partial moves to full.
// - Select fall starts recovery; needs tenth edge.
`timescale 1ns/1ns
`default_nettype none

module apus_sequencer #(
    parameter int unsigned REC_FULL_CYC = apus_pkg::REC_FULL_CYC // Full recovery count.
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Host pins.
    input  wire logic       conv_sel_n,
    input  wire logic       ser_clk,
    // Reference selection strap, high for the internal reference.
    input  wire logic       int_ref_sel,
    // Status outputs.
    output logic [1:0]      power_mode,
    output logic            fully_powered,
    output logic            ref_buf_on,
    output logic            track_mode,
    output logic            result_line_a_oe,
    output logic            result_line_b_oe
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // The recovery counter must hold the full recovery count; refuse it at elaboration.
    if (REC_FULL_CYC < 1 || REC_FULL_CYC >= (1 << apus_pkg::REC_W)) begin : g_bad_rec
        $error("Full recovery count does not fit the counter.");
    end

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    logic [1:0] sel_sync_q;   // Select synchroniser, bit 1 is safe.
    logic [1:0] sclk_sync_q;  // Serial clock synchroniser.
    logic [1:0] ref_sync_q;   // Reference strap synchroniser.
    logic       sel_d1_q;     // Delayed select for edge finding.
    logic       sclk_d1_q;    // Delayed serial clock for edge finding.

    // Each pin passes two flip-flops before use.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_sync_q  <= 2'h3;
            sclk_sync_q <= 2'h0;
            ref_sync_q  <= 2'h0;
            sel_d1_q    <= 1'b1;
            sclk_d1_q   <= 1'b0;
        end else begin
            sel_sync_q  <= {sel_sync_q[0], conv_sel_n};
            sclk_sync_q <= {sclk_sync_q[0], ser_clk};
            ref_sync_q  <= {ref_sync_q[0], int_ref_sel};
            sel_d1_q    <= sel_sync_q[1];
            sclk_d1_q   <= sclk_sync_q[1];
        end
    end

    // Edge strobes, one cycle each.
    logic sel_fall;
    logic sel_rise;
    logic sclk_fall;
    logic sclk_edge;
    assign sel_fall  = sel_d1_q & ~sel_sync_q[1];
    assign sel_rise  = ~sel_d1_q & sel_sync_q[1];
    assign sclk_fall = sclk_d1_q & ~sclk_sync_q[1];
    assign sclk_edge = sclk_d1_q ^ sclk_sync_q[1];

    // ------------------------------------------------------------------------
    // Falling edge counter
    // ------------------------------------------------------------------------
    logic [5:0] edge_cnt_q;   // Serial clock falling edges in this frame.
    logic       in_frame_q;   // High while select is low.

    // Counts falling edges from each select fall; saturates at the end.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_q <= 6'h00;
            in_frame_q <= 1'b0;
        end else if (sel_fall) begin
            edge_cnt_q <= 6'h00;
            in_frame_q <= 1'b1;
        end else if (sel_rise) begin
            in_frame_q <= 1'b0;
        end else if (in_frame_q && sclk_fall && edge_cnt_q != apus_pkg::EDGE_END) begin
            edge_cnt_q <= edge_cnt_q + 6'h01;
        end
    end

    // Window test used on every select rise.
    function automatic logic in_window(input logic [5:0] cnt);
        in_window = (cnt >= apus_pkg::EDGE_WIN_LO) && (cnt < apus_pkg::EDGE_WIN_HI);
    endfunction

    // ------------------------------------------------------------------------
    // Power mode machine
    // ------------------------------------------------------------------------
    apus_pkg::apus_mode_t mode_q; // Present power mode.
    logic                 recovering_q; // Frame is a recovery dummy.

    // Select rise decides the mode from the edge count.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q       <= apus_pkg::APUS_NORMAL;
            recovering_q <= 1'b0;
        end else if (sel_fall) begin
            // A fall begins recovery from a power-down mode.
            recovering_q <= (mode_q != apus_pkg::APUS_NORMAL);
        end else if (sel_rise) begin
            recovering_q <= 1'b0;
            if (in_window(edge_cnt_q)) begin
                // Rise in the window powers down one step.
                if (mode_q == apus_pkg::APUS_NORMAL) begin
                    mode_q <= apus_pkg::APUS_PARTIAL;
                end else begin
                    mode_q <= apus_pkg::APUS_FULL;
                end
            end else if (edge_cnt_q >= apus_pkg::EDGE_WIN_HI) begin
                // Past the tenth edge the device stays or becomes powered.
                mode_q <= apus_pkg::APUS_NORMAL;
            end
            // A rise before the second edge keeps the mode.
        end
    end

    // ------------------------------------------------------------------------
    // Recovery timer
    // ------------------------------------------------------------------------
    logic [apus_pkg::REC_W-1:0] rec_cnt_q; // Cycles left until fully powered.
    logic [apus_pkg::REC_W-1:0] rec_load;  // Count for the present recovery.

    // Recovery length depends on mode and reference.
    always_comb begin
        if (mode_q == apus_pkg::APUS_FULL) begin
            rec_load = apus_pkg::REC_W'(REC_FULL_CYC);
        end else if (ref_sync_q[1]) begin
            rec_load = apus_pkg::REC_W'(apus_pkg::REC_INT_CYC);
        end else begin
            rec_load = apus_pkg::REC_W'(apus_pkg::REC_EXT_CYC);
        end
    end

    // Loads on select fall from power-down, runs down, clears on abort.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rec_cnt_q <= '0;
        end else if (sel_fall && mode_q != apus_pkg::APUS_NORMAL) begin
            rec_cnt_q <= rec_load;
        end else if (sel_rise && edge_cnt_q < apus_pkg::EDGE_WIN_HI && recovering_q) begin
            rec_cnt_q <= '0;
        end else if (rec_cnt_q != '0) begin
            rec_cnt_q <= rec_cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    logic powered_d; // Fully powered when normal and recovery done.
    assign powered_d = (mode_q == apus_pkg::APUS_NORMAL) && (rec_cnt_q == '0);

    // Status outputs are registered.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_mode    <= 2'h0;
            fully_powered <= 1'b0;
            ref_buf_on    <= 1'b0;
        end else begin
            power_mode    <= mode_q;
            fully_powered <= powered_d && !recovering_q;
            // Buffers are off in power-down; on during recovery only if internal.
            ref_buf_on    <= ref_sync_q[1] &&
                             (mode_q == apus_pkg::APUS_NORMAL || recovering_q);
        end
    end

    // Track-and-hold control: starts in track at reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            track_mode <= 1'b1;
        end else if (sel_fall) begin
            track_mode <= 1'b0;
        end else if (in_frame_q && recovering_q && sclk_edge && edge_cnt_q == 6'h00) begin
            track_mode <= 1'b1;
        end else if (in_frame_q && !recovering_q && sclk_edge && sclk_sync_q[1]
                     && edge_cnt_q >= apus_pkg::EDGE_TRACK) begin
            track_mode <= 1'b1;
        end else if (!in_frame_q) begin
            track_mode <= 1'b1;
        end
    end

    // Result lines drive during a frame, tri-state on rise or dual-read end.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_line_a_oe <= 1'b0;
            result_line_b_oe <= 1'b0;
        end else if (sel_fall) begin
            result_line_a_oe <= 1'b1;
            result_line_b_oe <= 1'b1;
        end else if (sel_rise || (in_frame_q && edge_cnt_q == apus_pkg::EDGE_END)) begin
            result_line_a_oe <= 1'b0;
            result_line_b_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_window_partial;
        @(posedge clk) disable iff (!rst_n)
        (sel_rise && in_window(edge_cnt_q) && mode_q == apus_pkg::APUS_NORMAL)
        |=> mode_q == apus_pkg::APUS_PARTIAL;
    endproperty
    a_window_partial: assert property (p_window_partial) else $error("No partial entry.");

    property p_window_full;
        @(posedge clk) disable iff (!rst_n)
        (sel_rise && in_window(edge_cnt_q) && mode_q == apus_pkg::APUS_PARTIAL)
        |=> mode_q == apus_pkg::APUS_FULL;
    endproperty
    a_window_full: assert property (p_window_full) else $error("No full entry.");

    property p_early_rise;
        @(posedge clk) disable iff (!rst_n)
        (sel_rise && edge_cnt_q < apus_pkg::EDGE_WIN_LO) |=> $stable(mode_q);
    endproperty
    a_early_rise: assert property (p_early_rise) else $error("Early rise moved mode.");

    property p_tenth_normal;
        @(posedge clk) disable iff (!rst_n)
        (sel_rise && edge_cnt_q >= apus_pkg::EDGE_WIN_HI) |=> mode_q == apus_pkg::APUS_NORMAL;
    endproperty
    a_tenth_normal: assert property (p_tenth_normal) else $error("Not normal after ten.");

    property p_rise_tristate;
        @(posedge clk) disable iff (!rst_n)
        sel_rise |=> !result_line_a_oe && !result_line_b_oe;
    endproperty
    a_rise_tristate: assert property (p_rise_tristate) else $error("Lines still driven.");

    property p_ext_recovery;
        @(posedge clk) disable iff (!rst_n)
        (sel_fall && mode_q == apus_pkg::APUS_PARTIAL && !ref_sync_q[1])
        |=> rec_cnt_q == apus_pkg::REC_W'(apus_pkg::REC_EXT_CYC);
    endproperty
    a_ext_recovery: assert property (p_ext_recovery) else $error("Bad external load.");

    property p_int_recovery;
        @(posedge clk) disable iff (!rst_n)
        (sel_fall && mode_q == apus_pkg::APUS_PARTIAL && ref_sync_q[1])
        |=> rec_cnt_q == apus_pkg::REC_W'(apus_pkg::REC_INT_CYC);
    endproperty
    a_int_recovery: assert property (p_int_recovery) else $error("Bad internal load.");

    property p_ref_buf;
        @(posedge clk) disable iff (!rst_n)
        !ref_sync_q[1] |=> !ref_buf_on;
    endproperty
    a_ref_buf: assert property (p_ref_buf) else $error("Buffers on with external.");

    property p_track_return;
        @(posedge clk) disable iff (!rst_n)
        (in_frame_q && recovering_q && sclk_edge && edge_cnt_q == 6'h00 && !sel_fall)
        |=> track_mode;
    endproperty
    a_track_return: assert property (p_track_return) else $error("No track return.");

endmodule

`default_nettype wire

// ===== tb/apus_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Host model: drives select and the serial clock
// ----------------------------------------------------------------------------
module apus_host_model (
    // Timing reference.
    input  wire logic clk,
    // Host pins.
    output var logic  conv_sel_n,
    output var logic  ser_clk
);
    // Select idles high and the serial clock stands still low between frames.
    initial begin
        conv_sel_n = 1'b1;
        ser_clk    = 1'b0;
    end

    // Opens a frame and leaves a short lead before the first clock.
    task automatic sel_fall();
        @(negedge clk);
        conv_sel_n = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // One 400 ns serial clock period ending on a counted falling edge.
    task automatic pulse();
        ser_clk = 1'b1;
        repeat (4) @(negedge clk);
        ser_clk = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // Closes a frame and holds select high for at least the quiet time.
    task automatic sel_rise(input int unsigned hold_cyc);
        conv_sel_n = 1'b1;
        repeat (hold_cyc) @(negedge clk);
    endtask
endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Self-checking bench for the power sequencer
// ----------------------------------------------------------------------------
module testbench;
    localparam int unsigned REC_SIM = 400; // Shortened full recovery count.
    logic       clk;                       // System clock, 50 ns period.
    logic       rst_n;                     // Asynchronous reset, active low.
    logic       int_ref_sel;               // High selects the internal reference.
    logic       conv_sel_n;                // Select pin from the host model.
    logic       ser_clk;                   // Serial clock from the host model.
    logic [1:0] power_mode;                // Reported power mode.
    logic       fully_powered;             // Converter ready.
    logic       ref_buf_on;                // Reference buffers powered.
    logic       track_mode;                // Track (1) or hold (0).
    logic       oe_a;                      // Result line A driver enable.
    logic       oe_b;                      // Result line B driver enable.
    int         error_cnt;                 // Mismatches seen.
    int         checks_done;               // Comparisons made.

    always #25 clk = ~clk;

    apus_host_model host (.clk(clk), .conv_sel_n(conv_sel_n), .ser_clk(ser_clk));

    apus_sequencer #(.REC_FULL_CYC(REC_SIM)) dut (
        .clk(clk), .rst_n(rst_n), .conv_sel_n(conv_sel_n), .ser_clk(ser_clk),
        .int_ref_sel(int_ref_sel), .power_mode(power_mode),
        .fully_powered(fully_powered), .ref_buf_on(ref_buf_on), .track_mode(track_mode),
        .result_line_a_oe(oe_a), .result_line_b_oe(oe_b)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares one seen value with its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // Compares the mode, readiness and both driver enables together.
    task automatic check_state(input logic [1:0] m, input logic fp, input logic oe);
        check({30'h0, power_mode}, {30'h0, m});
        check({31'h0, fully_powered}, {31'h0, fp});
        check({30'h0, oe_a, oe_b}, {30'h0, oe, oe});
    endtask

    // A whole frame of n counted falling edges followed by the quiet time.
    task automatic frame(input int unsigned n);
        host.sel_fall();
        repeat (n) host.pulse();
        host.sel_rise(10);
    endtask

    // Values held during reset.
    task automatic t_reset();
        check_state(apus_pkg::APUS_NORMAL, 1'b0, 1'b0);
        check({31'h0, track_mode}, 32'h0000_0001);
    endtask

    // Mode-setting dummy frame after supplies, then a glitch-short frame.
    task automatic t_powerup();
        repeat (20) @(negedge clk);
        frame(12);
        check_state(apus_pkg::APUS_NORMAL, 1'b1, 1'b0);
        check({31'h0, ref_buf_on}, 32'h0000_0001);
        frame(1);
        check_state(apus_pkg::APUS_NORMAL, 1'b1, 1'b0);
    endtask

    // A full dual read in normal mode: track returns after 13 edges, drivers release at 32.
    task automatic t_dual_read();
        host.sel_fall();
        repeat (13) host.pulse();
        check({31'h0, track_mode}, 32'h0000_0000);
        host.pulse();
        check({31'h0, track_mode}, 32'h0000_0001);
        repeat (18) host.pulse();
        check({30'h0, oe_a, oe_b}, 32'h0000_0000);
        check({31'h0, fully_powered}, 32'h0000_0001);
        host.sel_rise(10);
        check_state(apus_pkg::APUS_NORMAL, 1'b1, 1'b0);
    endtask

    // Interrupt inside the window: outputs drive during, tri-state after.
    task automatic t_partial();
        host.sel_fall();
        repeat (5) host.pulse();
        check({30'h0, oe_a, oe_b}, 32'h0000_0003);
        check({31'h0, track_mode}, 32'h0000_0000);
        host.sel_rise(10);
        check_state(apus_pkg::APUS_PARTIAL, 1'b0, 1'b0);
        check({31'h0, ref_buf_on}, 32'h0000_0000);
    endtask

    // Dummy frame out of partial power-down; track returns on the first clock.
    task automatic t_recover(input logic ref_int);
        host.sel_fall();
        repeat (2) @(negedge clk);
        check({31'h0, track_mode}, 32'h0000_0000);
        check({31'h0, fully_powered}, 32'h0000_0000);
        host.pulse();
        check({31'h0, track_mode}, 32'h0000_0001);
        repeat (11) host.pulse();
        host.sel_rise(10);
        check_state(apus_pkg::APUS_NORMAL, 1'b1, 1'b0);
        check({31'h0, ref_buf_on}, {31'h0, ref_int});
    endtask

    // A short glitch keeps partial; a window rise moves on to full.
    task automatic t_to_full();
        frame(1);
        check_state(apus_pkg::APUS_PARTIAL, 1'b0, 1'b0);
        frame(5);
        check_state(apus_pkg::APUS_FULL, 1'b0, 1'b0);
    endtask

    // Leaving full power-down: ready only after the full recovery count.
    task automatic t_full_recover();
        int unsigned n;
        n = 4;
        host.sel_fall();
        fork
            begin
                repeat (12) host.pulse();
                host.sel_rise(10);
            end
            begin
                while (fully_powered !== 1'b1 && n < 1000) begin
                    @(negedge clk);
                    n++;
                end
            end
        join
        if (n >= 1000) begin
            error_cnt++;
            summarize();
        end
        check({31'h0, (n >= REC_SIM && n <= REC_SIM + 8)}, 32'h0000_0001);
        check_state(apus_pkg::APUS_NORMAL, 1'b1, 1'b0);
    endtask

    // Main sequence.
    initial begin
        clk         = 1'b0;
        rst_n       = 1'b0;
        int_ref_sel = 1'b1;
        error_cnt   = 0;
        checks_done = 0;
        repeat (4) @(negedge clk);
        t_reset();
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_powerup();
        t_dual_read();
        t_partial();
        t_recover(1'b1);
        t_partial();
        t_to_full();
        t_full_recover();
        int_ref_sel = 1'b0;
        repeat (10) @(negedge clk);
        t_partial();
        t_recover(1'b0);
        summarize();
    end
endmodule

`default_nettype wire
